//--- rtl/multi_mode_pulse_counter.sv
// two-channel signed 32-bit pulse counter with APB register access
// Function
// - host sets signal mode, then a gate-open edge starts counting
// - limits fixed by the signed 32-bit register, not configurable
// - modes: endless, one-time, periodic; latter two with or without direction
// - one-time and periodic use configurable load and end values
// - preset-load edge copies the set value into the count
// - without primary direction the whole signed range is usable
// - primary up: count to end-1, next pulse reloads load value
// - primary down: count to end+1, next pulse reloads load value
// - internal gate equals software gate; open and close on 0-1 edges
// - reopening resumes (interrupt) or restarts at load value (cancel)
// - endless: up pulse at upper limit wraps to lower limit
// - endless: down pulse at lower limit wraps to upper limit
// - limit passing sets sticky ovf/unf and alarm; cleared by status-clear edge
// - one-time no direction: limit pass jumps, closes gate, sets flag
// - after auto close host reopens; resume per interrupt/cancel
// - one-time up: pulse after end-1 reloads, closes gate, flags end
// - one-time down: pulse after end+1 reloads, closes gate, flags end
// - one-time with direction always restarts at load value on reopen
// - primary up: lower limit wraps to upper, sets underflow
// - primary down: upper limit wraps to lower, sets overflow
// - periodic no direction: limit returns to load value, sets flag
// - periodic up: pulse after end-1 reloads, gate stays open, flags end
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module multi_mode_pulse_counter (
   // clock and reset
   input  wire logic                          mclk_in,
   input  wire logic                          resetn_in,
   // apb slave
   input  wire logic                          psel_in,
   input  wire logic                          penable_in,
   input  wire logic                          pwrite_in,
   input  wire logic [7:0]                    paddr_in,
   input  wire logic [31:0]                   pwdata_in,
   output logic                               pready_out,
   output logic [31:0]                        prdata_out,
   output logic                               pslverr_out,
   // encoder pulses, one per channel
   input  wire pulse_counter_pkg::pulse_t [1:0] pulse_in,
   // process alarm pulses and gate state
   output logic [1:0]                         alarm_out,
   output logic [1:0]                         gate_out
);
   import pulse_counter_pkg::*;

   // ***************************************************************
   // apb front end
   // ***************************************************************
   logic              wr_en;
   logic [31:0]       rd_mux;
   logic              rd_hit;
   logic [31:0]       rd_word [CH_COUNT][7];
   logic [1:0]        alarm_ev;
   logic [1:0]        gate_now;

   // write takes effect only on the edge that completes the access
   assign wr_en = psel_in & penable_in & pready_out & pwrite_in;

   // read decode; unmapped addresses answer with an error and zero data
   always_comb begin
      rd_mux = RST_WORD;
      rd_hit = 1'b0;
      for (int c = 0; c < CH_COUNT; c++) begin
         for (int r = 0; r < 7; r++) begin
            if (paddr_in == 8'(c * 32'(CH_STRIDE) + r * 4)) begin
               rd_mux = rd_word[c][r];
               rd_hit = 1'b1;
            end
         end
      end
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= RST_WORD;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         prdata_out  <= (psel_in & penable_in & ~pready_out & ~pwrite_in) ? rd_mux : RST_WORD;
         pslverr_out <= psel_in & penable_in & ~pready_out & ~rd_hit;
      end
   end

   // registered side outputs
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         alarm_out <= 2'b00;
         gate_out  <= 2'b00;
      end else begin
         alarm_out <= alarm_ev;
         gate_out  <= gate_now;
      end
   end

   // ***************************************************************
   // counter channels
   // ***************************************************************
   for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
      logic [7:0]         base;
      logic [31:0]        ctrl;
      logic [31:0]        ctrl_prev;
      logic [31:0]        cfg_word;
      logic signed [31:0] load_val;
      logic signed [31:0] end_val;
      logic signed [31:0] set_val;
      logic signed [31:0] count;
      logic signed [31:0] next_count;
      logic               gate;
      logic               next_gate;
      logic               started;
      logic               ovf;
      logic               unf;
      logic               end_hit;
      logic               dir_up;
      logic               dir_down;
      logic               ovf_ev;
      logic               unf_ev;
      logic               end_ev;
      logic               open_edge;
      logic               close_edge;
      logic               preset_edge;
      logic               clr_edge;
      logic               step_up;
      logic               step_dn;
      chan_cfg_t          cfg;
      chan_stat_t         stat;

      assign base = 8'(g * 32'(CH_STRIDE));
      assign cfg  = chan_cfg_t'(cfg_word[8:0]);

      // control bits act on rising edges of the stored word
      assign open_edge   = ctrl[CTRL_GATE_OPEN]  & ~ctrl_prev[CTRL_GATE_OPEN];
      assign close_edge  = ctrl[CTRL_GATE_CLOSE] & ~ctrl_prev[CTRL_GATE_CLOSE];
      assign preset_edge = ctrl[CTRL_PRESET]     & ~ctrl_prev[CTRL_PRESET];
      assign clr_edge    = ctrl[CTRL_STAT_CLR]   & ~ctrl_prev[CTRL_STAT_CLR];
      // simultaneous up and down pulses cancel out
      assign step_up = pulse_in[g].up & ~pulse_in[g].down;
      assign step_dn = pulse_in[g].down & ~pulse_in[g].up;

      // ***************************************************************
      // channel registers
      // ***************************************************************
      // control word as last written; actions come from its 0-1 edges
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            ctrl <= RST_WORD;
         end else if (wr_en && paddr_in == base + 8'(OFF_CTRL)) begin
            ctrl <= pwdata_in;
         end
      end

      // previous control word, reference for edge detection
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            ctrl_prev <= RST_WORD;
         end else begin
            ctrl_prev <= ctrl;
         end
      end

      // configuration; unused upper bits read as zero
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            cfg_word <= RST_CFG;
         end else if (wr_en && paddr_in == base + 8'(OFF_CFG)) begin
            cfg_word <= {23'h0, pwdata_in[8:0]};
         end
      end

      // load value, start point of bounded modes
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            load_val <= RST_WORD;
         end else if (wr_en && paddr_in == base + 8'(OFF_LOAD)) begin
            load_val <= pwdata_in;
         end
      end

      // end value, bound of primary-direction modes
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            end_val <= RST_WORD;
         end else if (wr_en && paddr_in == base + 8'(OFF_END)) begin
            end_val <= pwdata_in;
         end
      end

      // set value; only used on a preset edge
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            set_val <= RST_WORD;
         end else if (wr_en && paddr_in == base + 8'(OFF_SET)) begin
            set_val <= pwdata_in;
         end
      end

      // ***************************************************************
      // next-state logic
      // ***************************************************************
      // next count and gate from pulses, mode and control edges
      always_comb begin
         next_count = count;
         next_gate  = gate;
         ovf_ev     = 1'b0;
         unf_ev     = 1'b0;
         end_ev     = 1'b0;
         if (preset_edge) begin
            next_count = set_val;
         end else if (gate && (step_up || step_dn)) begin
            next_count = step_up ? count + 32'sd1 : count - 32'sd1;
            unique case (cfg.mode)
               MODE_ENDLESS: begin
                  if (step_up && count == COUNT_MAX) begin
                     next_count = COUNT_MIN;
                     ovf_ev     = 1'b1;
                  end else if (step_dn && count == COUNT_MIN) begin
                     next_count = COUNT_MAX;
                     unf_ev     = 1'b1;
                  end
               end
               MODE_ONCE, MODE_PERIODIC: begin
                  unique case (cfg.dir)
                     DIR_UP: begin
                        if (step_up && count == end_val - 32'sd1) begin
                           next_count = load_val;
                           end_ev     = 1'b1;
                           if (cfg.mode == MODE_ONCE)
                              next_gate = 1'b0;
                        end else if (step_dn && count == COUNT_MIN) begin
                           next_count = COUNT_MAX;
                           unf_ev     = 1'b1;
                        end
                     end
                     DIR_DOWN: begin
                        if (step_dn && count == end_val + 32'sd1) begin
                           next_count = load_val;
                           end_ev     = 1'b1;
                           if (cfg.mode == MODE_ONCE)
                              next_gate = 1'b0;
                        end else if (step_up && count == COUNT_MAX) begin
                           next_count = COUNT_MIN;
                           ovf_ev     = 1'b1;
                        end
                     end
                     default: begin
                        // no primary direction: whole signed range
                        if ((step_up && count == COUNT_MAX) ||
                            (step_dn && count == COUNT_MIN)) begin
                           ovf_ev = step_up;
                           unf_ev = step_dn;
                           if (cfg.mode == MODE_ONCE) begin
                              next_count = step_up ? COUNT_MIN : COUNT_MAX;
                              next_gate  = 1'b0;
                           end else begin
                              next_count = load_val;
                           end
                        end
                     end
                  endcase
               end
               default: begin
                  next_count = count;  // illegal mode code: hold
               end
            endcase
         end
         // a gate opening without a configured signal mode is ignored
         if (open_edge && cfg.sig_en) begin
            next_gate = 1'b1;
            // first start, cancel, or one-time with direction restart at load
            if (!started || cfg.cancel ||
                (cfg.mode == MODE_ONCE && cfg.dir != DIR_NONE))
               next_count = load_val;
         end
         // close wins over open on the same edge so counting stops
         if (close_edge)
            next_gate = 1'b0;
      end

      // ***************************************************************
      // channel state and sticky flags
      // ***************************************************************
      // current count
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            count <= RST_WORD;
         end else begin
            count <= next_count;
         end
      end

      // internal gate; the software gate is the same bit
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            gate <= 1'b0;
         end else begin
            gate <= next_gate;
         end
      end

      // first opening after reset starts at the load value
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            started <= 1'b0;
         end else if (next_gate) begin
            started <= 1'b1;
         end
      end

      // last counted direction; held while no pulse counts
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            dir_up   <= 1'b0;
            dir_down <= 1'b0;
         end else if (gate && (step_up || step_dn)) begin
            dir_up   <= step_up;
            dir_down <= step_dn;
         end
      end

      // overflow; a new event wins over a clear in the same cycle
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            ovf <= 1'b0;
         end else begin
            ovf <= ovf_ev | (ovf & ~clr_edge);
         end
      end

      // underflow, same priority as overflow
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            unf <= 1'b0;
         end else begin
            unf <= unf_ev | (unf & ~clr_edge);
         end
      end

      // end value reached, same priority as overflow
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            end_hit <= 1'b0;
         end else begin
            end_hit <= end_ev | (end_hit & ~clr_edge);
         end
      end

      // alarm pulse on any flagged event when enabled
      assign alarm_ev[g] = cfg.alarm_en & (ovf_ev | unf_ev | end_ev);
      assign gate_now[g] = next_gate;

      // ***************************************************************
      // status and read-back
      // ***************************************************************
      // both gate bits show the one internal gate
      assign stat = '{dir_up:   dir_up,
                      dir_down: dir_down,
                      unf:      unf,
                      ovf:      ovf,
                      end_hit:  end_hit,
                      int_gate: gate,
                      software_gate:  gate,
                      rsvd:     1'b0};
      assign rd_word[g][0] = ctrl;
      assign rd_word[g][1] = cfg_word;
      assign rd_word[g][2] = load_val;
      assign rd_word[g][3] = end_val;
      assign rd_word[g][4] = set_val;
      assign rd_word[g][5] = count;
      assign rd_word[g][6] = {24'h000000, stat};
   end

endmodule

//--- rtl/pulse_counter_pkg.sv
// package: register map, field layout, modes and carriers of the pulse counter
package pulse_counter_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int          CH_COUNT      = 2;
   localparam logic [7:0]  CH_STRIDE     = 8'h20;
   localparam logic [4:0]  OFF_CTRL      = 5'h00;
   localparam logic [4:0]  OFF_CFG       = 5'h04;
   localparam logic [4:0]  OFF_LOAD      = 5'h08;
   localparam logic [4:0]  OFF_END       = 5'h0c;
   localparam logic [4:0]  OFF_SET       = 5'h10;
   localparam logic [4:0]  OFF_COUNT     = 5'h14;
   localparam logic [4:0]  OFF_STATUS    = 5'h18;

   // ***************************************************************
   // control word bits, acting on a 0-1 edge
   // ***************************************************************
   localparam int          CTRL_GATE_OPEN  = 2;
   localparam int          CTRL_PRESET     = 5;
   localparam int          CTRL_STAT_CLR   = 6;
   localparam int          CTRL_GATE_CLOSE = 10;

   // ***************************************************************
   // count limits and reset values
   // ***************************************************************
   localparam logic signed [31:0] COUNT_MAX   = 32'sh7fffffff;
   localparam logic signed [31:0] COUNT_MIN   = 32'sh80000000;
   localparam logic [31:0]        RST_WORD    = 32'h00000000;
   localparam logic [31:0]        RST_CFG     = 32'h00000011;

   // ***************************************************************
   // modes, one-hot
   // ***************************************************************
   typedef enum logic [2:0] {
      MODE_ENDLESS  = 3'b001,
      MODE_ONCE     = 3'b010,
      MODE_PERIODIC = 3'b100
   } count_mode_t;

   typedef enum logic [2:0] {
      DIR_NONE = 3'b001,
      DIR_UP   = 3'b010,
      DIR_DOWN = 3'b100
   } prim_dir_t;

   // ***************************************************************
   // carriers
   // ***************************************************************
   // configuration word layout (low bits of CFG)
   typedef struct packed {
      logic        alarm_en;  // bit 8
      logic        sig_en;    // bit 7
      logic        cancel;    // bit 6
      logic [2:0]  dir;       // bits 5:3
      logic [2:0]  mode;      // bits 2:0
   } chan_cfg_t;

   // status word layout (low bits of STATUS)
   typedef struct packed {
      logic  dir_up;      // bit 7
      logic  dir_down;    // bit 6
      logic  unf;         // bit 5
      logic  ovf;         // bit 4
      logic  end_hit;     // bit 3
      logic  int_gate;    // bit 2
      logic  software_gate;     // bit 1
      logic  rsvd;        // bit 0
   } chan_stat_t;

   // encoder pulse pair of one channel
   typedef struct packed {
      logic  up;
      logic  down;
   } pulse_t;

endpackage

//--- bench/pulse_source.sv
// encoder model: count pulses for either channel of the counter
`timescale 1ns/1ps
module pulse_source (
   // clock
   input  wire logic                       mclk_in,
   // pulse pairs {up,down}, one per channel
   output pulse_counter_pkg::pulse_t [1:0] pulse_out
);
   import pulse_counter_pkg::*;
   initial pulse_out = '0;
   // one cycle high per count, never both lines; gap slows the encoder down
   task automatic send(input int ch, input int n, input logic up, input int gap);
      repeat (n) begin
         @(posedge mclk_in);
         pulse_out[ch] <= up ? 2'b10 : 2'b01;
         @(posedge mclk_in);
         pulse_out[ch] <= 2'b00;
         repeat (gap) @(posedge mclk_in);
      end
   endtask
endmodule

//--- bench/pulse_counter_checker.sv
// checker: bus, gate and alarm relations at the counter ports
`timescale 1ns/1ps
module pulse_counter_checker (
   input wire logic                       mclk_in,
   input wire logic                       resetn_in,
   input wire logic                       psel_in,
   input wire logic                       penable_in,
   input wire logic                       pwrite_in,
   input wire logic [7:0]                 paddr_in,
   input wire logic [31:0]                pwdata_in,
   input wire logic                       pready_out,
   input wire logic [31:0]                prdata_out,
   input wire logic                       pslverr_out,
   input wire pulse_counter_pkg::pulse_t [1:0] pulse_in,
   input wire logic [1:0]                 alarm_out,
   input wire logic [1:0]                 gate_out
);
   import pulse_counter_pkg::*;
   logic [3:0] wr_age;
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   // cycles since the last write landed; saturates so old writes never excuse a gate change
   always_ff @(posedge mclk_in) begin
      if (!resetn_in)
         wr_age <= 4'hf;
      else if (pready_out && pwrite_in)
         wr_age <= 4'h0;
      else if (wr_age != 4'hf)
         wr_age <= wr_age + 4'h1;
   end
   chk_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("pready longer than one cycle");
   chk_ready_time: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("pready not in second access cycle");
   chk_ready_cause: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
      else $error("pready without access");
   chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside answer");
   chk_err_unmapped: assert property (pready_out && paddr_in[1:0] == 2'b00 |->
      pslverr_out == (paddr_in[4:0] > 5'h18 || paddr_in > 8'h3f))
      else $error("error flag wrong for address");
   chk_reset_idle: assert property (disable iff (1'b0)
      !resetn_in |=> !pready_out && gate_out == 2'b00 && alarm_out == 2'b00)
      else $error("outputs active in reset");
   for (genvar g = 0; g < 2; g++) begin : ch_g
      chk_alarm_cause: assert property (alarm_out[g] |->
         $past(gate_out[g] && (pulse_in[g].up ^ pulse_in[g].down)))
         else $error("alarm without counted pulse");
      chk_gate_open: assert property ($rose(gate_out[g]) |-> wr_age < 4'h5)
         else $error("gate opened without control write");
      chk_gate_close: assert property ($fell(gate_out[g]) |->
         wr_age < 4'h5 || $past(pulse_in[g].up ^ pulse_in[g].down))
         else $error("gate closed without cause");
   end
   cov_alarm: cover property (alarm_out[0]);
   cov_auto_close: cover property ($fell(gate_out[0]) ##0 wr_age > 4'h4);
   cov_refused: cover property (pslverr_out);
endmodule
bind multi_mode_pulse_counter pulse_counter_checker chk_u (.mclk_in, .resetn_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
   .pulse_in, .alarm_out, .gate_out);

//--- bench/testbench.sv
// self-checking bench: apb sequences against the two-channel pulse counter
`timescale 1ns/1ps
module testbench;
   import pulse_counter_pkg::*;
   logic         mclk_in = 1'b0;
   logic         resetn_in = 1'b0;
   logic         psel_in = 1'b0;
   logic         penable_in = 1'b0;
   logic         pwrite_in = 1'b0;
   logic [7:0]   paddr_in = 8'h00;
   logic [31:0]  pwdata_in = 32'h0;
   logic         pready_out, pslverr_out, err;
   logic [31:0]  prdata_out, rdat;
   logic [1:0]   alarm_out, gate_out;
   pulse_t [1:0] pulse_w;
   int           n_errors = 0, num_checks = 0, n_alarm = 0;

   always #2 mclk_in = ~mclk_in;
   // alarm pulses of both channels, counted per scenario
   always @(posedge mclk_in) n_alarm <= n_alarm + int'(alarm_out[0]) + int'(alarm_out[1]);

   multi_mode_pulse_counter dut_u (.mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .pulse_in(pulse_w),
      .alarm_out, .gate_out);
   pulse_source src_u (.mclk_in, .pulse_out(pulse_w));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   function automatic logic [7:0] ad(input int ch, input logic [4:0] off);
      return (ch == 1 ? CH_STRIDE : 8'h00) + {3'h0, off};
   endfunction

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge mclk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk_in);
         i++;
      end while (pready_out !== 1'b1 && i < 16);
      if (i >= 16) begin
         n_errors++;
         $display("ERROR pready expected 1 seen 0");
         report_and_stop;
      end
      rdat = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk(nm, e, rdat);
   endtask

   // actions fire on a 0-1 change only, so the bit is set and then cleared
   task automatic ctrl(input int ch, input int b);
      apb(ad(ch, OFF_CTRL), 1'b1, 32'h1 << b);
      apb(ad(ch, OFF_CTRL), 1'b1, 32'h0);
      repeat (2) @(posedge mclk_in);
   endtask

   // configure, reopen the gate, optionally preset, count, then check the outcome
   task automatic sc(input int ch, input logic [2:0] m, d, input logic c,
      input logic [31:0] ld, en, sv, input logic pre, input int n, input logic up,
      input logic [31:0] ec, input logic eg, input logic [2:0] ef);
      int a0;
      apb(ad(ch, OFF_LOAD), 1'b1, ld);
      apb(ad(ch, OFF_END), 1'b1, en);
      apb(ad(ch, OFF_SET), 1'b1, sv);
      apb(ad(ch, OFF_CFG), 1'b1, {23'h0, 2'b11, c, d, m});
      ctrl(ch, CTRL_GATE_CLOSE);
      ctrl(ch, CTRL_STAT_CLR);
      ctrl(ch, CTRL_GATE_OPEN);
      if (pre)
         ctrl(ch, CTRL_PRESET);
      a0 = n_alarm;
      src_u.send(ch, n, up, up ? 0 : 2);
      repeat (2) @(posedge mclk_in);
      rc("count", ad(ch, OFF_COUNT), ec);
      chk("gate", {31'h0, eg}, {31'h0, gate_out[ch]});
      apb(ad(ch, OFF_STATUS), 1'b0, 32'h0);
      chk("flags", {29'h0, ef}, {29'h0, rdat[5:3]});
      chk("dir", {30'h0, up, !up}, {30'h0, rdat[7:6]});
      chk("gate bits", {30'h0, eg, eg}, {30'h0, rdat[2:1]});
      chk("alarms", {31'h0, ef != 3'h0}, 32'(n_alarm - a0));
      $display("test ch %0d mode %h dir %h done", ch, m, d);
   endtask

   initial begin
      repeat (16) @(posedge mclk_in);
      resetn_in <= 1'b1;
      // reset values, a read-only write and an unmapped place
      rc("cfg", ad(0, OFF_CFG), RST_CFG);
      rc("load", ad(1, OFF_LOAD), RST_WORD);
      apb(ad(0, OFF_COUNT), 1'b1, 32'h55);
      rc("count", ad(0, OFF_COUNT), RST_WORD);
      apb(8'h1c, 1'b0, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      ctrl(0, CTRL_GATE_OPEN);
      chk("gate", 32'h0, {31'h0, gate_out[0]});
      $display("test reset done");
      sc(0, MODE_ENDLESS, DIR_NONE, 1, 5, 0, 0, 0, 3, 1, 8, 1, 3'b000);
      ctrl(0, CTRL_GATE_CLOSE);
      src_u.send(0, 2, 1'b1, 0);
      rc("count", ad(0, OFF_COUNT), 32'd8);
      sc(1, MODE_ENDLESS, DIR_NONE, 1, 7, 0, 0, 0, 2, 1, 9, 1, 3'b000);
      rc("count", ad(0, OFF_COUNT), 32'd8);
      sc(0, MODE_ENDLESS, DIR_NONE, 1, 0, 0, COUNT_MAX, 1, 1, 1,
         COUNT_MIN, 1, 3'b010);
      sc(0, MODE_ENDLESS, DIR_NONE, 1, 0, 0, COUNT_MIN, 1, 1, 0,
         COUNT_MAX, 1, 3'b100);
      sc(0, MODE_ONCE, DIR_NONE, 1, 0, 0, COUNT_MAX, 1, 1, 1, COUNT_MIN, 0, 3'b010);
      sc(0, MODE_ONCE, DIR_NONE, 1, 0, 0, COUNT_MIN, 1, 1, 0,
         COUNT_MAX, 0, 3'b100);
      sc(0, MODE_ONCE, DIR_UP, 1, 10, 13, 0, 0, 3, 1, 10, 0, 3'b001);
      sc(0, MODE_ONCE, DIR_UP, 0, 9, 13, 0, 0, 2, 1, 11, 1, 3'b000);
      sc(0, MODE_ONCE, DIR_DOWN, 1, 10, 7, 0, 0, 3, 0, 10, 0, 3'b001);
      sc(0, MODE_PERIODIC, DIR_UP, 1, 0, 3, 0, 0, 3, 1, 0, 1, 3'b001);
      sc(0, MODE_PERIODIC, DIR_NONE, 1, 4, 0, COUNT_MAX, 1, 1, 1, 4, 1, 3'b010);
      sc(0, MODE_PERIODIC, DIR_UP, 1, 0, 100, COUNT_MIN, 1, 1, 0, COUNT_MAX, 1, 3'b100);
      sc(0, MODE_PERIODIC, DIR_DOWN, 1, 0, 0, COUNT_MAX, 1, 1, 1, COUNT_MIN, 1, 3'b010);
      sc(0, MODE_ONCE, DIR_NONE, 0, 0, 0, COUNT_MAX, 1, 1, 1, COUNT_MIN, 0, 3'b010);
      ctrl(0, CTRL_GATE_OPEN);
      rc("count", ad(0, OFF_COUNT), COUNT_MIN);
      $display("test resume done");
      report_and_stop;
   end
endmodule
